// ==== core_pkg.sv ====
// Purpose: Shared constants and types for the instruction execution core.
// Assumes: 16-bit instruction words, 8-bit data, word-addressed program memory.
// Notes:   Opcodes are recognised as (word & mask) == match.
package core_pkg;

	// Datapath sizes.
	localparam int PC_W        = 9;
	localparam int STACK_DEPTH = 3;
	localparam logic [8:0] PC_ONE = 9'h001;

	// Flag register bit positions.
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	// I/O address at which the flag register itself is seen.
	localparam logic [5:0] IO_FLAG_ADDR = 6'h3F;
	localparam logic [7:0] MASK_CLEAR   = 8'hFF;
	localparam logic [4:0] Z_LOW_REG    = 5'h1E;

	// Opcode masks.
	localparam logic [15:0] M_RR   = 16'hFC00;
	localparam logic [15:0] M_IMM  = 16'hF000;
	localparam logic [15:0] M_RBIT = 16'hFE08;
	localparam logic [15:0] M_IOB  = 16'hFF00;
	localparam logic [15:0] M_BR   = 16'hFC00;
	localparam logic [15:0] M_FULL = 16'hFFFF;
	localparam logic [15:0] M_LDST = 16'hFE0F;
	localparam logic [15:0] M_IO   = 16'hF800;

	// Opcode match values.
	localparam logic [15:0] OP_ADD   = 16'h0C00;
	localparam logic [15:0] OP_ADC   = 16'h1C00;
	localparam logic [15:0] OP_SUB   = 16'h1800;
	localparam logic [15:0] OP_SBCR  = 16'h0800;
	localparam logic [15:0] OP_AND   = 16'h2000;
	localparam logic [15:0] OP_XOR   = 16'h2400;
	localparam logic [15:0] OP_OR    = 16'h2800;
	localparam logic [15:0] OP_MOV   = 16'h2C00;
	localparam logic [15:0] OP_CP    = 16'h1400;
	localparam logic [15:0] OP_CMPC  = 16'h0400;
	localparam logic [15:0] OP_CMPSK = 16'h1000;
	localparam logic [15:0] OP_SUBK  = 16'h5000;
	localparam logic [15:0] OP_SBCK  = 16'h4000;
	localparam logic [15:0] OP_ANDK  = 16'h7000;
	localparam logic [15:0] OP_ORK   = 16'h6000;
	localparam logic [15:0] OP_CMPK  = 16'h3000;
	localparam logic [15:0] OP_LDI   = 16'hE000;
	localparam logic [15:0] OP_RBC   = 16'hFC00;
	localparam logic [15:0] OP_RBS   = 16'hFE00;
	localparam logic [15:0] OP_IOBC  = 16'h9900;
	localparam logic [15:0] OP_IOBS  = 16'h9B00;
	localparam logic [15:0] OP_BSET  = 16'hF000;
	localparam logic [15:0] OP_BCLR  = 16'hF400;
	localparam logic [15:0] OP_JREL  = 16'hC000;
	localparam logic [15:0] OP_CREL  = 16'hD000;
	localparam logic [15:0] OP_RET   = 16'h9508;
	localparam logic [15:0] OP_IRET  = 16'h9518;
	localparam logic [15:0] OP_LD    = 16'h8000;
	localparam logic [15:0] OP_ST    = 16'h8200;
	localparam logic [15:0] OP_IN    = 16'hB000;
	localparam logic [15:0] OP_OUT   = 16'hB800;

	// Extra wait cycles after the execute cycle, before the refetch cycle.
	localparam logic [1:0] WAIT_CALL = 2'h1;
	localparam logic [1:0] WAIT_RET  = 2'h2;

	typedef enum logic [2:0] {
		ALU_PASS, ALU_ADD, ALU_ADC, ALU_SUB, ALU_SUBC, ALU_AND, ALU_OR, ALU_XOR
	} alu_op_t;

	// Gray coded along execute -> wait -> memory.
	typedef enum logic [1:0] {
		ST_EXEC = 2'b00,
		ST_WAIT = 2'b01,
		ST_MEM  = 2'b11
	} core_state_e_t;

	typedef struct packed {
		core_state_e_t                     state;
		logic                              valid;
		logic [15:0]                       instr;
		logic [PC_W-1:0]                   pc;
		logic [1:0]                        wait_cnt;
		logic [31:0][7:0]                  rf;
		logic [7:0]                        flags;
		logic [STACK_DEPTH-1:0][PC_W-1:0]  stack;
		logic [5:0]                        io_raddr;
		logic                              io_re;
		logic [5:0]                        io_waddr;
		logic                              io_we;
		logic [7:0]                        io_wdata;
		logic [7:0]                        dmem_addr;
		logic                              dmem_re;
		logic                              dmem_we;
		logic [7:0]                        dmem_wdata;
		logic [4:0]                        ld_dst;
	} core_state_t;

endpackage

// ==== alu_if.sv ====
// Purpose: Carries operands and results between the core and its ALU.
// Assumes: Purely combinational exchange within one cycle.
// Notes:   Flags travel as a whole byte; the ALU returns the updated byte.
`timescale 1ns/1ps
interface alu_if;
	core_pkg::alu_op_t op;
	logic [7:0]        a;
	logic [7:0]        b;
	logic [7:0]        flags_in;
	logic [7:0]        result;
	logic [7:0]        flags_out;

	modport core (output op, output a, output b, output flags_in,
		input result, input flags_out);
	modport alu (input op, input a, input b, input flags_in,
		output result, output flags_out);
endinterface

// ==== exec_alu.sv ====
// Purpose: 8-bit arithmetic and logic unit with flag generation.
// Assumes: Operands are stable for the whole cycle.
// Notes:   ALU_PASS leaves every flag untouched.
`timescale 1ns/1ps
module exec_alu
(
	// Operand and result channel.
	alu_if.alu bus
);

	////////////////////////////////////////////////////////////////////////
	// Result and flag computation.
	always_comb
	begin
		logic [8:0] sum;
		logic [8:0] dif;
		logic [7:0] r;
		logic [7:0] f;
		logic       cin;
		sum = 9'h000;
		dif = 9'h000;
		r   = bus.a;
		f   = bus.flags_in;
		cin = bus.flags_in[core_pkg::FLAG_C];
		sum = {1'b0, bus.a} + {1'b0, bus.b} + {8'h00, (bus.op == core_pkg::ALU_ADC) & cin};
		dif = {1'b0, bus.a} - {1'b0, bus.b} - {8'h00, (bus.op == core_pkg::ALU_SUBC) & cin};
		case (bus.op)
			core_pkg::ALU_ADD, core_pkg::ALU_ADC:
			begin
				r = sum[7:0];
				f[core_pkg::FLAG_C] = sum[8];
				f[core_pkg::FLAG_H] = (bus.a[3] & bus.b[3]) | (bus.b[3] & ~r[3]) | (~r[3] & bus.a[3]);
				f[core_pkg::FLAG_V] = (bus.a[7] & bus.b[7] & ~r[7]) | (~bus.a[7] & ~bus.b[7] & r[7]);
			end
			core_pkg::ALU_SUB, core_pkg::ALU_SUBC:
			begin
				r = dif[7:0];
				f[core_pkg::FLAG_C] = dif[8];
				f[core_pkg::FLAG_H] = (~bus.a[3] & bus.b[3]) | (bus.b[3] & r[3]) | (r[3] & ~bus.a[3]);
				f[core_pkg::FLAG_V] = (bus.a[7] & ~bus.b[7] & ~r[7]) | (~bus.a[7] & bus.b[7] & r[7]);
			end
			core_pkg::ALU_AND:
			begin
				r = bus.a & bus.b;
				f[core_pkg::FLAG_V] = 1'b0;
			end
			core_pkg::ALU_OR:
			begin
				r = bus.a | bus.b;
				f[core_pkg::FLAG_V] = 1'b0;
			end
			core_pkg::ALU_XOR:
			begin
				r = bus.a ^ bus.b;
				f[core_pkg::FLAG_V] = 1'b0;
			end
			default:
			begin
				r = bus.a;
			end
		endcase
		// Zero after a borrow-chained subtraction only stays set if it was set, so
		// multi-byte compares see zero over the whole word.
		if (bus.op != core_pkg::ALU_PASS)
		begin
			f[core_pkg::FLAG_N] = r[7];
			f[core_pkg::FLAG_Z] = (r == 8'h00) &
				((bus.op != core_pkg::ALU_SUBC) | bus.flags_in[core_pkg::FLAG_Z]);
			f[core_pkg::FLAG_S] = f[core_pkg::FLAG_N] ^ f[core_pkg::FLAG_V];
		end
		bus.result    = r;
		bus.flags_out = f;
	end

endmodule // exec_alu

// ==== exec_core.sv ====
// Purpose: Fetch and execute core for an 8-bit instruction subset.
// Assumes: Program, data and I/O memories answer combinationally in the cycle
//          their registered address is shown.
// Notes:   Fetch overlaps execute, so a redirect costs one flush cycle.
//
// Overview of operation
// - Add, add-with-carry write sum, set six flags.
// - Register subtract with borrow, six flags, one cycle.
// - Immediate subtract with borrow, six flags.
// - Immediate subtract, six flags, one cycle.
// - Logic ops set Z,N,V; keep C,H.
// - Set-bits ORs the mask in.
// - Clear-bits ANDs with FFh minus mask.
// - Test ANDs register with itself, flags only.
// - Compares set flags, never write a register.
// - Compare-skip-equal skips next, one or two cycles.
// - Register-bit skip on clear or set bit.
// - I/O-bit skip on clear or set bit.
// - Flag branch to pc plus offset plus one.
// - Zero, carry, negative branches test their flag.
// - Unsigned branches test carry clear or set.
// - Signed branches test negative xor overflow.
// - Half-carry, transfer, overflow branches both polarities.
// - Interrupt branches test global interrupt enable.
`timescale 1ns/1ps
module exec_core
(
	// Clock and reset.
	input  wire logic                      clock_in,
	input  wire logic                      sys_rst_in,
	// Program memory.
	output logic [core_pkg::PC_W-1:0]      pmem_addr_out,
	input  wire logic [15:0]               pmem_data_in,
	// I/O space.
	output logic [5:0]                     io_raddr_out,
	output logic                           io_re_out,
	input  wire logic [7:0]                io_rdata_in,
	output logic [5:0]                     io_waddr_out,
	output logic                           io_we_out,
	output logic [7:0]                     io_wdata_out,
	// Data memory reached through the Z pointer.
	output logic [7:0]                     dmem_addr_out,
	output logic                           dmem_re_out,
	output logic                           dmem_we_out,
	output logic [7:0]                     dmem_wdata_out,
	input  wire logic [7:0]                dmem_rdata_in,
	// Status.
	output logic [7:0]                     cpu_flag_register_out
);

	core_pkg::core_state_t st_r;
	core_pkg::core_state_t st_nxt;
	alu_if                 alu_bus ();

	logic [15:0] ins;
	logic [4:0]  rd_idx;
	logic [4:0]  src_reg;
	logic [4:0]  imm_idx;
	logic [7:0]  rd_val;
	logic [7:0]  rr_val;
	logic [7:0]  imm_val;
	logic [4:0]  alu_dst;
	logic        alu_wr;
	logic        alu_use;
	logic        exec_v;

	function automatic logic hit(input logic [15:0] w, input logic [15:0] m,
		input logic [15:0] p);
		return (w & m) == p;
	endfunction

	exec_alu u_alu
	(
		.bus (alu_bus.alu)
	);

	////////////////////////////////////////////////////////////////////////
	// Operand fields of the instruction in execute.
	assign ins     = st_r.instr;
	assign rd_idx  = ins[8:4];
	assign src_reg = {ins[9], ins[3:0]};
	assign imm_idx = {1'b1, ins[7:4]};
	assign imm_val = {ins[11:8], ins[3:0]};
	assign rd_val  = st_r.rf[rd_idx];
	assign rr_val  = st_r.rf[src_reg];
	assign exec_v  = (st_r.state == core_pkg::ST_EXEC) & st_r.valid;

	////////////////////////////////////////////////////////////////////////
	// ALU operation select; compares use the ALU but do not write back.
	always_comb
	begin
		alu_bus.op       = core_pkg::ALU_PASS;
		alu_bus.a        = rd_val;
		alu_bus.b        = rr_val;
		alu_bus.flags_in = st_r.flags;
		alu_dst          = rd_idx;
		alu_wr           = 1'b0;
		alu_use          = 1'b1;
		if (hit(ins, core_pkg::M_RR, core_pkg::OP_ADD))
		begin
			alu_bus.op = core_pkg::ALU_ADD;
			alu_wr     = 1'b1;
		end
		else if (hit(ins, core_pkg::M_RR, core_pkg::OP_ADC))
		begin
			alu_bus.op = core_pkg::ALU_ADC;
			alu_wr     = 1'b1;
		end
		else if (hit(ins, core_pkg::M_RR, core_pkg::OP_SUB))
		begin
			alu_bus.op = core_pkg::ALU_SUB;
			alu_wr     = 1'b1;
		end
		else if (hit(ins, core_pkg::M_RR, core_pkg::OP_SBCR))
		begin
			alu_bus.op = core_pkg::ALU_SUBC;
			alu_wr     = 1'b1;
		end
		else if (hit(ins, core_pkg::M_RR, core_pkg::OP_AND))
		begin
			// With both operands the same register this is the zero/minus test.
			alu_bus.op = core_pkg::ALU_AND;
			alu_wr     = 1'b1;
		end
		else if (hit(ins, core_pkg::M_RR, core_pkg::OP_OR))
		begin
			alu_bus.op = core_pkg::ALU_OR;
			alu_wr     = 1'b1;
		end
		else if (hit(ins, core_pkg::M_RR, core_pkg::OP_XOR))
		begin
			alu_bus.op = core_pkg::ALU_XOR;
			alu_wr     = 1'b1;
		end
		else if (hit(ins, core_pkg::M_RR, core_pkg::OP_CP))
		begin
			alu_bus.op = core_pkg::ALU_SUB;
		end
		else if (hit(ins, core_pkg::M_RR, core_pkg::OP_CMPC))
		begin
			alu_bus.op = core_pkg::ALU_SUBC;
		end
		else if (ins[15:14] != 2'b10 && ins[15:13] != 3'b111 && ins[15:12] != 4'h0 &&
			ins[15:12] != 4'h1 && ins[15:12] != 4'h2)
		begin
			// Register-immediate forms address only the upper sixteen registers.
			alu_bus.a = st_r.rf[imm_idx];
			alu_bus.b = imm_val;
			alu_dst   = imm_idx;
			case (ins[15:12])
				core_pkg::OP_SUBK[15:12]: begin alu_bus.op = core_pkg::ALU_SUB; alu_wr = 1'b1; end
				core_pkg::OP_SBCK[15:12]: begin alu_bus.op = core_pkg::ALU_SUBC; alu_wr = 1'b1; end
				// The assembler folds clear-bits into this form with FFh minus the mask.
				core_pkg::OP_ANDK[15:12]: begin alu_bus.op = core_pkg::ALU_AND; alu_wr = 1'b1; end
				core_pkg::OP_ORK[15:12]:  begin alu_bus.op = core_pkg::ALU_OR;  alu_wr = 1'b1; end
				core_pkg::OP_CMPK[15:12]: alu_bus.op = core_pkg::ALU_SUB;
				default:                  alu_use = 1'b0;
			endcase
		end
		else
		begin
			alu_use = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state logic: execute, wait and data-memory cycles, then fetch.
	always_comb
	begin
		logic                      do_fetch;
		logic                      keep;
		logic                      redirect;
		logic                      cond;
		logic [15:0]               w;
		do_fetch       = 1'b0;
		keep           = 1'b1;
		redirect       = 1'b0;
		cond           = 1'b0;
		w              = pmem_data_in;
		st_nxt         = st_r;
		st_nxt.io_re   = 1'b0;
		st_nxt.io_we   = 1'b0;
		st_nxt.dmem_re = 1'b0;
		st_nxt.dmem_we = 1'b0;
		case (st_r.state)
			core_pkg::ST_EXEC:
			begin
				do_fetch = 1'b1;
				if (st_r.valid)
				begin
					if (alu_use)
					begin
						st_nxt.flags = alu_bus.flags_out;
						if (alu_wr)
							st_nxt.rf[alu_dst] = alu_bus.result;
					end
					else if (hit(ins, core_pkg::M_RR, core_pkg::OP_MOV))
						st_nxt.rf[rd_idx] = rr_val;
					else if (hit(ins, core_pkg::M_IMM, core_pkg::OP_LDI))
						st_nxt.rf[imm_idx] = imm_val;
					else if (hit(ins, core_pkg::M_RR, core_pkg::OP_CMPSK))
						keep = ~(rd_val == rr_val);
					else if (hit(ins, core_pkg::M_RBIT, core_pkg::OP_RBC))
						keep = rd_val[ins[2:0]];
					else if (hit(ins, core_pkg::M_RBIT, core_pkg::OP_RBS))
						keep = ~rd_val[ins[2:0]];
					else if (hit(ins, core_pkg::M_IOB, core_pkg::OP_IOBC))
						keep = io_rdata_in[ins[2:0]];
					else if (hit(ins, core_pkg::M_IOB, core_pkg::OP_IOBS))
						keep = ~io_rdata_in[ins[2:0]];
					else if (hit(ins, core_pkg::M_BR, core_pkg::OP_BSET) ||
						hit(ins, core_pkg::M_BR, core_pkg::OP_BCLR))
					begin
						// Selectable bit covers Z/C/N, S for signed, H, T, V and I.
						cond = st_r.flags[ins[2:0]] ^ ins[10];
						if (cond)
						begin
							st_nxt.pc = st_r.pc + {{2{ins[9]}}, ins[9:3]};
							redirect  = 1'b1;
							keep      = 1'b0;
						end
					end
					else if (hit(ins, core_pkg::M_IMM, core_pkg::OP_JREL) ||
						hit(ins, core_pkg::M_IMM, core_pkg::OP_CREL))
					begin
						st_nxt.pc = st_r.pc + ins[8:0];
						redirect  = 1'b1;
						do_fetch  = 1'b0;
						st_nxt.valid = 1'b0;
						if (ins[12])
						begin
							// Return address is the word after the call.
							for (int i = core_pkg::STACK_DEPTH - 1; i > 0; i--)
								st_nxt.stack[i] = st_r.stack[i-1];
							st_nxt.stack[0]  = st_r.pc;
							st_nxt.wait_cnt  = core_pkg::WAIT_CALL;
							st_nxt.state     = core_pkg::ST_WAIT;
						end
					end
					else if (hit(ins, core_pkg::M_FULL, core_pkg::OP_RET) ||
						hit(ins, core_pkg::M_FULL, core_pkg::OP_IRET))
					begin
						st_nxt.pc = st_r.stack[0];
						for (int i = 0; i < core_pkg::STACK_DEPTH - 1; i++)
							st_nxt.stack[i] = st_r.stack[i+1];
						if (ins[4])
							st_nxt.flags[core_pkg::FLAG_I] = 1'b1;
						do_fetch        = 1'b0;
						st_nxt.valid    = 1'b0;
						st_nxt.wait_cnt = core_pkg::WAIT_RET;
						st_nxt.state    = core_pkg::ST_WAIT;
					end
					else if (hit(ins, core_pkg::M_LDST, core_pkg::OP_LD) ||
						hit(ins, core_pkg::M_LDST, core_pkg::OP_ST))
					begin
						// Fetch stalls one cycle while the data access is under way.
						do_fetch          = 1'b0;
						st_nxt.dmem_addr  = st_r.rf[core_pkg::Z_LOW_REG];
						st_nxt.dmem_re    = ~ins[9];
						st_nxt.dmem_we    = ins[9];
						st_nxt.dmem_wdata = rd_val;
						st_nxt.ld_dst     = rd_idx;
						st_nxt.state      = core_pkg::ST_MEM;
					end
					else if (hit(ins, core_pkg::M_IO, core_pkg::OP_IN))
						st_nxt.rf[rd_idx] = (st_r.io_raddr == core_pkg::IO_FLAG_ADDR) ?
							st_r.flags : io_rdata_in;
					else if (hit(ins, core_pkg::M_IO, core_pkg::OP_OUT))
					begin
						if ({ins[10:9], ins[3:0]} == core_pkg::IO_FLAG_ADDR)
							st_nxt.flags = rd_val;
						else
						begin
							st_nxt.io_we    = 1'b1;
							st_nxt.io_waddr = {ins[10:9], ins[3:0]};
							st_nxt.io_wdata = rd_val;
						end
					end
				end
			end
			core_pkg::ST_WAIT:
			begin
				st_nxt.valid    = 1'b0;
				st_nxt.wait_cnt = st_r.wait_cnt - 2'h1;
				if (st_r.wait_cnt == 2'h1)
					st_nxt.state = core_pkg::ST_EXEC;
			end
			core_pkg::ST_MEM:
			begin
				if (st_r.dmem_re)
					st_nxt.rf[st_r.ld_dst] = dmem_rdata_in;
				do_fetch     = 1'b1;
				st_nxt.state = core_pkg::ST_EXEC;
			end
			default:
			begin
				st_nxt.state = core_pkg::ST_EXEC;
				st_nxt.valid = 1'b0;
			end
		endcase
		// A dropped word still moves the counter, which gives the skip its two cycles.
		if (do_fetch)
		begin
			st_nxt.instr = w;
			st_nxt.valid = keep;
			if (!redirect)
				st_nxt.pc = st_r.pc + core_pkg::PC_ONE;
			// Reads are started only for words that will execute, so a read with side
			// effects on a dropped path never reaches the I/O space.
			if (keep && hit(w, core_pkg::M_IO, core_pkg::OP_IN))
			begin
				st_nxt.io_re    = 1'b1;
				st_nxt.io_raddr = {w[10:9], w[3:0]};
			end
			else if (keep && (hit(w, core_pkg::M_IOB, core_pkg::OP_IOBC) ||
				hit(w, core_pkg::M_IOB, core_pkg::OP_IOBS)))
			begin
				st_nxt.io_re    = 1'b1;
				st_nxt.io_raddr = {1'b0, w[7:3]};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge clock_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// All outputs are fields of the state register.
	assign pmem_addr_out         = st_r.pc;
	assign io_raddr_out          = st_r.io_raddr;
	assign io_re_out             = st_r.io_re;
	assign io_waddr_out          = st_r.io_waddr;
	assign io_we_out             = st_r.io_we;
	assign io_wdata_out          = st_r.io_wdata;
	assign dmem_addr_out         = st_r.dmem_addr;
	assign dmem_re_out           = st_r.dmem_re;
	assign dmem_we_out           = st_r.dmem_we;
	assign dmem_wdata_out        = st_r.dmem_wdata;
	assign cpu_flag_register_out = st_r.flags;

	////////////////////////////////////////////////////////////////////////
	// Checks on the execute behaviour.
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);

	add_result_a: assert property (exec_v && hit(ins, core_pkg::M_RR, core_pkg::OP_ADD)
		|=> st_r.rf[$past(rd_idx)] == 8'($past(rd_val) + $past(rr_val)) && exec_v == st_r.valid)
		else $error("add result or timing wrong");
	sbc_result_a: assert property (exec_v && hit(ins, core_pkg::M_RR, core_pkg::OP_SBCR)
		|=> st_r.rf[$past(rd_idx)] == 8'($past(rd_val) - $past(rr_val)
		- {7'h00, $past(st_r.flags[core_pkg::FLAG_C])}))
		else $error("subtract with borrow result wrong");
	logic_keeps_a: assert property (exec_v && (hit(ins, core_pkg::M_RR, core_pkg::OP_AND) ||
		hit(ins, core_pkg::M_RR, core_pkg::OP_OR) || hit(ins, core_pkg::M_RR, core_pkg::OP_XOR))
		|=> $stable(st_r.flags[core_pkg::FLAG_C]) && $stable(st_r.flags[core_pkg::FLAG_H])
		&& !st_r.flags[core_pkg::FLAG_V])
		else $error("logic op disturbed carry or half-carry");
	compare_nowrite_a: assert property (exec_v && (hit(ins, core_pkg::M_RR, core_pkg::OP_CP) ||
		hit(ins, core_pkg::M_IMM, core_pkg::OP_CMPK)) |=> $stable(st_r.rf))
		else $error("compare wrote a register");
	skip_equal_a: assert property (exec_v && hit(ins, core_pkg::M_RR, core_pkg::OP_CMPSK)
		&& rd_val == rr_val |=> !st_r.valid ##1 st_r.pc == $past(st_r.pc, 2) + 9'h002)
		else $error("equal compare did not skip");
	branch_target_a: assert property (exec_v && hit(ins, core_pkg::M_BR, core_pkg::OP_BSET)
		&& st_r.flags[ins[2:0]] |=> !st_r.valid
		&& st_r.pc == $past(st_r.pc) + {{2{$past(ins[9])}}, $past(ins[9:3])})
		else $error("taken branch target wrong");
	branch_fall_a: assert property (exec_v && hit(ins, core_pkg::M_BR, core_pkg::OP_BCLR)
		&& st_r.flags[ins[2:0]] |=> st_r.pc == $past(st_r.pc) + core_pkg::PC_ONE
		&& st_r.state == core_pkg::ST_EXEC)
		else $error("untaken branch did not fall through");
	ret_cycles_a: assert property (exec_v && hit(ins, core_pkg::M_FULL, core_pkg::OP_RET)
		|=> (!exec_v)[*3])
		else $error("return took too few cycles");
	call_cycles_a: assert property (exec_v && hit(ins, core_pkg::M_IMM, core_pkg::OP_CREL)
		|=> st_r.stack[0] == $past(st_r.pc) ##0 (!exec_v)[*2])
		else $error("call push or timing wrong");
	move_flags_a: assert property (exec_v && (hit(ins, core_pkg::M_RR, core_pkg::OP_MOV) ||
		hit(ins, core_pkg::M_IMM, core_pkg::OP_LDI)) |=> $stable(st_r.flags))
		else $error("move changed flags");
	load_two_a: assert property (exec_v && hit(ins, core_pkg::M_LDST, core_pkg::OP_LD)
		|=> dmem_re_out && st_r.state == core_pkg::ST_MEM ##1 st_r.state == core_pkg::ST_EXEC)
		else $error("indirect load not two cycles");

endmodule // exec_core

// ==== mem_model.sv ====
// Purpose: Program, I/O and data memories seen by the execution core.
// Assumes: Combinational reads, writes on the rising clock edge.
// Notes:   The bench loads the program array directly before each run.
`timescale 1ns/1ps
module mem_model
(
	// Clock.
	input  wire logic        clock_in,
	// Program and I/O side.
	input  wire logic [8:0]  pmem_addr_in,
	output logic [15:0]      pmem_data_out,
	input  wire logic        io_re_in,
	output logic [7:0]       io_rdata_out,
	// Data side.
	input  wire logic [7:0]  dmem_addr_in,
	input  wire logic        dmem_re_in,
	input  wire logic        dmem_we_in,
	input  wire logic [7:0]  dmem_wdata_in,
	output logic [7:0]       dmem_rdata_out
);
	logic [15:0] rom [512];
	logic [7:0]  ram [256];
	logic [7:0]  tick = 8'h00;
	////////////////////////////////////////////////////////////////////////////
	// Stores land on the edge that ends the strobe cycle.
	always @(posedge clock_in)
	begin
		tick <= tick + 8'h01;
		if (dmem_we_in === 1'b1)
			ram[dmem_addr_in] <= dmem_wdata_in;
	end
	// Unstrobed reads show a moving pattern, so stale data never looks valid.
	assign pmem_data_out  = rom[pmem_addr_in];
	assign io_rdata_out   = io_re_in ? 8'h3C : tick;
	assign dmem_rdata_out = dmem_re_in ? ram[dmem_addr_in] : ~tick;
endmodule // mem_model

// ==== tb.sv ====
// Purpose: Self-checking bench for the execution core.
// Assumes: Each program ends in no-ops; results leave through port writes.
// Notes:   Gaps between port writes expose instruction cycle counts.
`timescale 1ns/1ps
module tb;
	logic clock_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [8:0] pa;
	logic [15:0] pd;
	logic [5:0] ra, wa;
	logic re, we, dre, dwe;
	logic [7:0] rd, wd, da, dwd, drd, fl;
	int fails = 0;
	int compares = 0;
	int cyc = 0;
	logic [7:0] got_b[$];
	logic [7:0] got_f[$];
	int got_t[$];
	exec_core i_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .pmem_addr_out(pa),
		.pmem_data_in(pd), .io_raddr_out(ra), .io_re_out(re), .io_rdata_in(rd),
		.io_waddr_out(wa), .io_we_out(we), .io_wdata_out(wd), .dmem_addr_out(da),
		.dmem_re_out(dre), .dmem_we_out(dwe), .dmem_wdata_out(dwd),
		.dmem_rdata_in(drd), .cpu_flag_register_out(fl));
	mem_model i_mem (.clock_in(clock_in), .pmem_addr_in(pa), .pmem_data_out(pd),
		.io_re_in(re), .io_rdata_out(rd), .dmem_addr_in(da), .dmem_re_in(dre),
		.dmem_we_in(dwe), .dmem_wdata_in(dwd), .dmem_rdata_out(drd));
	////////////////////////////////////////////////////////////////////////////
	// Clock, port-write capture and hang guard.
	always #2.5 clock_in = ~clock_in;
	always @(posedge clock_in)
	begin
		cyc <= cyc + 1;
		if (we === 1'b1)
		begin
			got_b.push_back(wd);
			got_f.push_back(fl);
			got_t.push_back(cyc);
		end
		if (cyc == 3000)
		begin
			fails++;
			give_verdict();
		end
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Loads a program under reset, runs it and judges the two port writes.
	task automatic run(input string nm, input logic [15:0] p [8], input logic [7:0] b0,
		input logic [7:0] b1, input logic [7:0] f, input logic [7:0] gap);
		@(posedge clock_in);
		sys_rst_in <= 1'b1;
		for (int i = 0; i < 512; i++)
			i_mem.rom[i] = (i < 8) ? p[i] : 16'h0000;
		got_b.delete();
		got_f.delete();
		got_t.delete();
		repeat (5) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		repeat (30) @(posedge clock_in);
		check("writes", 8'(got_b.size()), 8'h02);
		if (got_b.size() == 2)
		begin
			check("first", got_b[0], b0);
			check("second", got_b[1], b1);
			check("flags", got_f[1], f);
			check("gap", 8'(got_t[1] - got_t[0]), gap);
		end
		$display("test %s done", nm);
	endtask
	// 78h plus 88h wraps to zero with carry and half-carry.
	task automatic add_flags();
		run("add", '{16'hE708, 16'hE818, 16'h0F01, 16'hBB00, 16'hBB00, 0, 0, 0},
			8'h00, 8'h00, 8'h23, 8'h01);
	endtask
	// Zero minus one sets carry, so the branch hops over one load.
	task automatic sub_branch();
		run("branch", '{16'hE000, 16'h5001, 16'hBB00, 16'hF008, 16'hEA0A, 16'hBB00, 0, 0},
			8'hFF, 8'hFF, 8'h35, 8'h03);
	endtask
	// Store then load through Z, then an equal compare skips one load.
	task automatic mem_skip();
		run("memory", '{16'hE0E5, 16'hE412, 16'h8310, 16'h8100, 16'hBB00, 16'h1301,
			16'hEA0A, 16'hBB00}, 8'h42, 8'h42, 8'h00, 8'h03);
	endtask
	// A port read feeds a write, then a set-bit test on that port skips one load.
	task automatic io_skip();
		run("io", '{16'hB300, 16'hBB00, 16'h9B82, 16'hEA0A, 16'hBB00, 0, 0, 0},
			8'h3C, 8'h3C, 8'h00, 8'h03);
	endtask
	// A call of three cycles and a return of four sit between two port writes.
	task automatic call_ret();
		run("call", '{16'hBB00, 16'hD002, 16'hBB00, 16'hCFFF, 16'h9508, 0, 0, 0},
			8'h00, 8'h00, 8'h00, 8'h08);
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		add_flags();
		sub_branch();
		mem_skip();
		io_skip();
		call_ret();
		give_verdict();
	end
endmodule // tb
